/* core/cbm_ctrl.sv */
`timescale 1ns/1ps
`include "cbm_defs.svh"
//
// Behaviour
// (RQ1) Payload sent from byte zero, MSB first
// (RQ2) Byte count follows the length code
// (RQ3) Pending transmit buffers compete before start
// (RQ4) Lowest local priority value wins
// (RQ5) Ties go to the lowest buffer index
// (RQ6) Stop-in-wait freezes module during CPU wait
// (RQ7) Synced status bit readable
// (RQ8) Timer link routes module timer signal
// (RQ9) Sleep acknowledge reads one while asleep
// (RQ10) Sleep request puts module to sleep
// (RQ11) Soft reset aborts frames, drops sync
// (RQ12) Soft reset holds control and flags reset
// (RQ13) Config registers writable only in soft reset
// (RQ14) Error counters untouched by soft reset
// (RQ15) Resync after 11 recessive bits, 128 if bus-off
// (RQ16) Software clears soft reset alone
// (RQ17) Loop-back: internal feed, pin stays recessive
// (RQ18) Loop-back ignores acknowledge, both events raised
// (RQ19) Wakeup on edge or filtered dominant pulse
// (RQ20) Clock source select bit
// (RQ21) Control B writes ignored outside soft reset
// (RQ22) Remote frame sends length, no data
// (RQ23) Receive buffer read-only, transmit buffers read-write
// (RQ24) Sleep acknowledge follows real sleep entry and exit
module cbm_ctrl #(
    parameter int BIT_CYC = `CBM_BIT_CYC,
    parameter int WAKE_NS = `CBM_WAKE_NS,
    parameter int NUM_TX = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bus_receive_pin,
    output logic bus_transmit_pin,
    input wire logic cpu_wait,
    input wire logic bus_off,
    input wire logic timer_port_pin,
    output logic timer_input,
    output logic module_clk_run,
    output logic module_clock_select,
    output logic tx_done_pulse,
    output logic rx_done_pulse,
    output logic wakeup_pulse
);
    localparam int WAKE_CYC = (WAKE_NS * `CBM_CLK_MHZ + 999) / 1000;
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYC / 2);
    localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYC - 1);

    cbm_pkg::cbm_regs_t q, d;
    logic addr_ok;
    logic [7:0] a_idx;
    logic halt;
    logic rx_bit;
    logic samp;
    logic last;
    logic drive;
    logic store;
    logic [4:0] lbits;
    logic [3:0] nb;
    logic any_pend;
    logic [1:0] win;
    logic [7:0] best;
    logic cpu_we;
    logic b_we;
    logic [4:0] b_addr;
    logic [7:0] a_rdata;
    logic [7:0] b_rdata;
    logic [7:0] rd8;

    function automatic logic is_pay(input logic [7:0] idx);
        return idx[7:4] >= `CBM_BUF_RX && idx[7:4] <= `CBM_BUF_TX_LAST
            && idx[3:0] >= `CBM_REG_PAY_FIRST
            && idx[3:0] <= `CBM_REG_PAY_LAST;
    endfunction : is_pay

    function automatic logic [4:0] ram_addr(input logic [7:0] idx);
        return {idx[5:4], 3'(idx[3:0] - `CBM_REG_PAY_FIRST)};
    endfunction : ram_addr

    function automatic logic is_buf(input logic [7:0] idx);
        return idx[7:4] >= `CBM_BUF_RX && idx[7:4] <= `CBM_BUF_TX_LAST;
    endfunction : is_buf

    assign addr_ok = hsel & hready & htrans[1];
    assign a_idx = haddr[9:2];
    assign halt = q.stop_in_wait & cpu_wait; // see RQ6
    assign rx_bit = q.loopback ? q.tx_q : q.rx_s2; // see RQ17
    // Receive buffer takes no CPU writes
    assign cpu_we = q.wr_pend & is_pay(q.wr_idx)
        & (q.wr_idx[5:4] != 2'h0); // see RQ23
    assign store = ~q.tx_act | q.loopback;
    assign samp = q.cyc == BIT_HALF;
    assign last = q.cyc == BIT_LAST;
    assign drive = q.cyc == 16'h0001;
    assign lbits = q.len[q.cur];
    assign b_we = ~halt & ~q.soft_reset & store & last
        & q.st == cbm_pkg::cbm_st_data & q.bcnt == `CBM_BYTE_LAST;
    assign b_addr = b_we ? {2'h0, q.bidx} : {q.cur, q.bidx};

    cbm_buf_ram #(
        .DW(8),
        .AW(5)
    ) u_ram (
        .clk(hclk),
        .a_we(cpu_we),
        .a_waddr(ram_addr(q.wr_idx)),
        .a_wdata(hwdata[7:0]),
        .a_raddr(ram_addr(a_idx)),
        .a_rdata(a_rdata),
        .b_we(b_we),
        .b_addr(b_addr),
        .b_wdata(q.sh),
        .b_rdata(b_rdata)
    );

    // Local arbitration; strict compare keeps the lower index on a tie
    always_comb begin
        any_pend = 1'b0;
        win = 2'h0;
        best = 8'hff;
        for (int i = 0; i < NUM_TX; i++) begin
            if (!q.tx_empty[i] && (!any_pend || q.prio[i] < best)) begin
                any_pend = 1'b1; // see RQ3
                best = q.prio[i]; // see RQ4
                win = 2'(i); // see RQ5
            end
        end
    end

    always_comb begin
        d = q;
        nb = 4'h0;
        d.tx_done = 1'b0;
        d.rx_done = 1'b0;
        d.wake = 1'b0;
        d.timer_sig = 1'b0;
        d.rx_s1 = bus_receive_pin;
        d.rx_s2 = q.rx_s1;
        d.rx_prev = q.rx_s2;
        d.pt_s1 = timer_port_pin;
        d.pt_s2 = q.pt_s1;
        d.wr_pend = addr_ok & hwrite;
        d.wr_idx = a_idx;
        d.rd_pend = addr_ok & ~hwrite;
        d.rd_mem = addr_ok & ~hwrite & is_pay(a_idx);
        d.rd_idx = a_idx;
        if (q.wr_pend) begin
            if (q.wr_idx == `CBM_IDX_CTL_A) begin
                d.soft_reset = hwdata[`CBM_A_SOFT]; // see RQ11
                d.sleep_req = hwdata[`CBM_A_SLEEP_REQUEST];
                d.timer_link = hwdata[`CBM_A_TLNK];
                d.stop_in_wait = hwdata[`CBM_A_SWAI];
            end
            if (q.wr_idx == `CBM_IDX_CTL_B && q.soft_reset) begin
                d.loopback = hwdata[`CBM_B_LOOP]; // see RQ13 RQ21
                d.wake_mode = hwdata[`CBM_B_WAKEM];
                d.clk_sel = hwdata[`CBM_B_CLKSEL];
            end
            if (q.wr_idx == `CBM_IDX_TXE) begin
                d.tx_empty = q.tx_empty & ~hwdata[2:0];
            end
            if (is_buf(q.wr_idx) && q.wr_idx[5:4] != 2'h0) begin
                if (q.wr_idx[3:0] == `CBM_REG_LEN) begin
                    d.len[q.wr_idx[5:4]] = hwdata[4:0]; // see RQ23
                end
                if (q.wr_idx[3:0] == `CBM_REG_PRIO) begin
                    d.prio[2'(q.wr_idx[5:4] - 2'h1)] = hwdata[7:0];
                end
            end
        end
        if (!halt) begin
            d.cyc = last ? 16'h0000 : q.cyc + 16'h0001;
            unique case (q.st)
                cbm_pkg::cbm_st_idle: begin
                    d.tx_q = 1'b1;
                    d.tx_act = 1'b0;
                    if (samp) begin
                        if (!rx_bit) begin
                            d.rec = 4'h0;
                        end else if (q.rec == `CBM_SYNC_BITS - 4'h1) begin
                            d.rec = 4'h0;
                            // A bus-off node needs 128 such runs
                            if (!bus_off) begin
                                d.synced = 1'b1; // see RQ15 RQ14
                            end else if (q.runs == `CBM_BOFF_RUNS - 8'h01) begin
                                d.synced = 1'b1; // see RQ15
                                d.runs = 8'h00;
                            end else begin
                                d.runs = q.runs + 8'h01;
                            end
                        end else begin
                            d.rec = q.rec + 4'h1;
                        end
                    end
                    if (q.synced && !q.sleep_ack && !q.loopback
                        && q.rx_prev && !q.rx_s2) begin
                        d.st = cbm_pkg::cbm_st_sof;
                        d.cyc = 16'h0001;
                    end else if (q.synced && !q.sleep_req && any_pend
                        && last) begin
                        d.st = cbm_pkg::cbm_st_sof; // see RQ3
                        d.cur = win + 2'h1;
                        d.tx_act = 1'b1;
                        d.timer_sig = 1'b1;
                    end
                end
                cbm_pkg::cbm_st_sof: begin
                    if (drive && q.tx_act) begin
                        d.tx_q = 1'b0;
                    end
                    if (last) begin
                        d.st = cbm_pkg::cbm_st_len;
                        d.bcnt = 3'h0;
                    end
                end
                cbm_pkg::cbm_st_len: begin
                    // Remote flag first, then the length code MSB first
                    if (drive && q.tx_act) begin
                        d.tx_q = lbits[3'h4 - q.bcnt]; // see RQ22
                    end
                    if (samp) begin
                        d.rxlen = {q.rxlen[3:0], rx_bit};
                    end
                    if (last && q.bcnt == `CBM_LEN_LAST) begin
                        if (q.rxlen[`CBM_LEN_REMOTE]) begin
                            nb = 4'h0; // see RQ22
                        end else if (q.rxlen[3:0] > `CBM_MAX_BYTES) begin
                            nb = `CBM_MAX_BYTES; // see RQ2
                        end else begin
                            nb = q.rxlen[3:0]; // see RQ2
                        end
                        d.nbytes = nb;
                        d.bidx = 3'h0;
                        d.bcnt = 3'h0;
                        d.st = (nb == 4'h0) ? cbm_pkg::cbm_st_ack
                            : cbm_pkg::cbm_st_data;
                    end else if (last) begin
                        d.bcnt = q.bcnt + 3'h1;
                    end
                end
                cbm_pkg::cbm_st_data: begin
                    if (drive && q.tx_act) begin
                        d.tx_q = b_rdata[`CBM_BYTE_LAST - q.bcnt]; // see RQ1
                    end
                    if (samp) begin
                        d.sh = {q.sh[6:0], rx_bit};
                    end
                    if (last) begin
                        d.bcnt = q.bcnt + 3'h1;
                        if (q.bcnt == `CBM_BYTE_LAST) begin
                            d.bidx = q.bidx + 3'h1; // see RQ1
                            if ({1'b0, q.bidx} == q.nbytes - 4'h1) begin
                                d.st = cbm_pkg::cbm_st_ack; // see RQ2
                            end
                        end
                    end
                end
                cbm_pkg::cbm_st_ack: begin
                    if (drive) begin
                        d.tx_q = q.tx_act;
                    end
                    if (samp) begin
                        d.ack_ok = ~rx_bit | q.loopback; // see RQ18
                    end
                    if (last) begin
                        d.st = cbm_pkg::cbm_st_eof;
                        d.bcnt = 3'h0;
                    end
                end
                cbm_pkg::cbm_st_eof: begin
                    if (drive) begin
                        d.tx_q = 1'b1;
                    end
                    if (last && q.bcnt == `CBM_EOF_LAST) begin
                        d.st = cbm_pkg::cbm_st_idle;
                        if (q.tx_act && q.ack_ok) begin
                            d.tx_empty[q.cur - 2'h1] = 1'b1;
                            d.tx_done = 1'b1; // see RQ18
                        end
                        if (store) begin
                            d.len[0] = q.rxlen;
                            d.rx_done = 1'b1; // see RQ18
                        end
                    end else if (last) begin
                        d.bcnt = q.bcnt + 3'h1;
                    end
                end
                default: begin
                    d.st = cbm_pkg::cbm_st_idle;
                end
            endcase
        end
        if (q.sleep_req && !q.sleep_ack && d.st == cbm_pkg::cbm_st_idle) begin
            d.sleep_ack = 1'b1; // see RQ10 RQ24
        end
        if (!d.sleep_req) begin
            d.sleep_ack = 1'b0; // see RQ24
        end
        d.wcnt = q.rx_s2 ? 16'h0000 : q.wcnt + 16'h0001;
        if (q.sleep_ack && (q.wake_mode ? q.wcnt == WAKE_LAST
            : q.rx_prev && !q.rx_s2)) begin
            d.sleep_ack = 1'b0; // see RQ19 RQ24
            d.sleep_req = 1'b0;
            d.wake = 1'b1;
        end
        if (d.soft_reset) begin
            d.stop_in_wait = 1'b0; // see RQ12
            d.timer_link = 1'b0;
            d.sleep_req = 1'b0;
            d.sleep_ack = 1'b0;
            d.tx_empty = `CBM_TXE_RST;
            d.st = cbm_pkg::cbm_st_idle; // see RQ11
            d.synced = 1'b0;
            d.rec = 4'h0;
            d.runs = 8'h00;
            d.tx_q = 1'b1;
            d.tx_act = 1'b0;
            d.cyc = 16'h0000;
        end
        d.pin = d.loopback | d.tx_q; // see RQ17
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.soft_reset <= `CBM_SOFT_RST;
            q.tx_empty <= `CBM_TXE_RST;
            q.tx_q <= 1'b1;
            q.pin <= 1'b1;
            q.rx_s1 <= 1'b1;
            q.rx_s2 <= 1'b1;
            q.rx_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        rd8 = 8'h00;
        if (q.rd_mem) begin
            rd8 = a_rdata;
        end else if (q.rd_pend) begin
            if (q.rd_idx == `CBM_IDX_CTL_A) begin
                rd8[`CBM_A_SOFT] = q.soft_reset;
                rd8[`CBM_A_SLEEP_REQUEST] = q.sleep_req;
                rd8[`CBM_A_SLEEP_ACK] = q.sleep_ack; // see RQ9
                rd8[`CBM_A_TLNK] = q.timer_link;
                rd8[`CBM_A_SYNC] = q.synced; // see RQ7
                rd8[`CBM_A_SWAI] = q.stop_in_wait;
            end else if (q.rd_idx == `CBM_IDX_CTL_B) begin
                rd8[`CBM_B_LOOP] = q.loopback;
                rd8[`CBM_B_WAKEM] = q.wake_mode;
                rd8[`CBM_B_CLKSEL] = q.clk_sel;
            end else if (q.rd_idx == `CBM_IDX_TXE) begin
                rd8 = {5'h00, q.tx_empty};
            end else if (is_buf(q.rd_idx)) begin
                if (q.rd_idx[3:0] == `CBM_REG_LEN) begin
                    rd8 = {3'h0, q.len[q.rd_idx[5:4]]};
                end else if (q.rd_idx[3:0] == `CBM_REG_PRIO
                    && q.rd_idx[5:4] != 2'h0) begin
                    rd8 = q.prio[2'(q.rd_idx[5:4] - 2'h1)];
                end
            end
        end
    end

    assign hrdata = {24'h000000, rd8};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign bus_transmit_pin = q.pin;
    assign timer_input = q.timer_link ? q.timer_sig : q.pt_s2; // see RQ8
    assign module_clk_run = ~halt; // see RQ6
    assign module_clock_select = q.clk_sel; // see RQ20
    assign tx_done_pulse = q.tx_done;
    assign rx_done_pulse = q.rx_done;
    assign wakeup_pulse = q.wake;

    logic prio_ok;
    always_comb begin
        prio_ok = 1'b1;
        for (int i = 0; i < NUM_TX; i++) begin
            if (!q.tx_empty[i] && (q.prio[i] < q.prio[win]
                || (q.prio[i] == q.prio[win] && 2'(i) < win))) begin
                prio_ok = 1'b0;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_tx_start;
        q.st == cbm_pkg::cbm_st_idle && d.st == cbm_pkg::cbm_st_sof
            && d.tx_act && !d.soft_reset;
    endsequence

    chk_tx_sof_low: assert property ( // see RQ3 RQ17
        s_tx_start ##0 !q.stop_in_wait |-> ##[1:3] (!q.tx_q
            && (q.loopback || !bus_transmit_pin)))
        else $error("start of frame not driven dominant");
    chk_prio_win: assert property ( // see RQ4 RQ5
        s_tx_start |-> prio_ok && any_pend)
        else $error("wrong buffer won local arbitration");
    chk_loop_pin: assert property ( // see RQ17
        q.loopback |-> bus_transmit_pin)
        else $error("transmit pin dominant in loop-back");
    chk_ctlb_lock: assert property ( // see RQ21
        q.wr_pend && q.wr_idx == `CBM_IDX_CTL_B && !q.soft_reset
            |=> $stable({q.loopback, q.wake_mode, q.clk_sel}))
        else $error("control b changed outside soft reset");
    chk_soft_hold: assert property ( // see RQ12
        q.soft_reset |-> q.tx_empty == `CBM_TXE_RST && !q.synced
            && q.st == cbm_pkg::cbm_st_idle && !q.sleep_req)
        else $error("state not held during soft reset");
    chk_sync_delay: assert property ( // see RQ15
        $fell(q.soft_reset) |-> !q.synced [*8])
        else $error("synced too soon after soft reset");
    chk_wait_freeze: assert property ( // see RQ6
        halt && !(q.wr_pend && q.wr_idx == `CBM_IDX_CTL_A)
            |=> $stable(q.cyc) && $stable(q.st))
        else $error("engine moved during wait");
    chk_timer_route: assert property ( // see RQ8
        s_tx_start ##0 q.timer_link |=> timer_input)
        else $error("timer link did not pass frame start");
    chk_sleep_ack_req: assert property ( // see RQ24
        q.sleep_ack |-> q.sleep_req && q.st == cbm_pkg::cbm_st_idle)
        else $error("sleep acknowledge without sleep");
    chk_wake_edge: assert property ( // see RQ19
        q.sleep_ack && !q.wake_mode && q.rx_prev && !q.rx_s2
            && !q.wr_pend |=> !q.sleep_ack && wakeup_pulse)
        else $error("edge wakeup missed");
endmodule : cbm_ctrl

/* core/cbm_defs.svh */
`ifndef CBM_DEFS_SVH
`define CBM_DEFS_SVH

// Register indexes; byte address = 4 * index
`define CBM_IDX_CTL_A 8'h00
`define CBM_IDX_CTL_B 8'h01
`define CBM_IDX_TXE 8'h06
// Buffer block in index[7:4]: 4 receive, 5..7 transmit
`define CBM_BUF_RX 4'h4
`define CBM_BUF_TX_LAST 4'h7
// Register within a buffer block in index[3:0]
`define CBM_REG_PAY_FIRST 4'h4
`define CBM_REG_PAY_LAST 4'hb
`define CBM_REG_LEN 4'hc
`define CBM_REG_PRIO 4'hd

// module_control_a fields
`define CBM_A_SOFT 0
`define CBM_A_SLEEP_REQUEST 1
`define CBM_A_SLEEP_ACK 2
`define CBM_A_TLNK 3
`define CBM_A_SYNC 4
`define CBM_A_SWAI 5
// module_control_b fields
`define CBM_B_CLKSEL 0
`define CBM_B_WAKEM 1
`define CBM_B_LOOP 2
// Length register fields
`define CBM_LEN_REMOTE 4

// Reset values
`define CBM_SOFT_RST 1'b1
`define CBM_TXE_RST 3'h7

// Timing
`define CBM_CLK_MHZ 100
`define CBM_BIT_CYC 100
`define CBM_WAKE_NS 5000
`define CBM_SYNC_BITS 4'hb
`define CBM_BOFF_RUNS 8'h80
`define CBM_MAX_BYTES 4'h8
`define CBM_LEN_LAST 3'h4
`define CBM_BYTE_LAST 3'h7
`define CBM_EOF_LAST 3'h6

`endif

/* core/cbm_pkg.sv */
package cbm_pkg;

    typedef enum logic [2:0] {
        cbm_st_idle = 3'b000,
        cbm_st_sof = 3'b001,
        cbm_st_len = 3'b010,
        cbm_st_data = 3'b011,
        cbm_st_ack = 3'b100,
        cbm_st_eof = 3'b101
    } cbm_state_t;

    typedef struct packed {
        logic soft_reset;
        logic sleep_req;
        logic sleep_ack;
        logic timer_link;
        logic stop_in_wait;
        logic synced;
        logic loopback;
        logic wake_mode;
        logic clk_sel;
        logic [2:0] tx_empty;
        logic [3:0][4:0] len;
        logic [2:0][7:0] prio;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic rd_pend;
        logic rd_mem;
        logic [7:0] rd_idx;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic pt_s1;
        logic pt_s2;
        cbm_state_t st;
        logic [15:0] cyc;
        logic [2:0] bcnt;
        logic [2:0] bidx;
        logic [3:0] nbytes;
        logic [4:0] rxlen;
        logic [7:0] sh;
        logic [1:0] cur;
        logic tx_act;
        logic ack_ok;
        logic tx_q;
        logic pin;
        logic [3:0] rec;
        logic [7:0] runs;
        logic [15:0] wcnt;
        logic tx_done;
        logic rx_done;
        logic wake;
        logic timer_sig;
    } cbm_regs_t;

endpackage : cbm_pkg

/* core/cbm_buf_ram.sv */
`timescale 1ns/1ps
// Payload byte store, port a for the CPU, port b for the frame engine
module cbm_buf_ram #(
    parameter int DW = 8,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic a_we,
    input wire logic [AW-1:0] a_waddr,
    input wire logic [DW-1:0] a_wdata,
    input wire logic [AW-1:0] a_raddr,
    output logic [DW-1:0] a_rdata,
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DW-1:0] b_wdata,
    output logic [DW-1:0] b_rdata
);
    logic [DW-1:0] mem [2**AW];

    // Contents undefined out of reset, so no reset here
    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_waddr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        // Write-through so a read right after a write sees new data
        a_rdata <= (a_we && a_waddr == a_raddr) ? a_wdata : mem[a_raddr];
        b_rdata <= mem[b_addr];
    end
endmodule : cbm_buf_ram

/* sim/cbm_bus_node.sv */
`timescale 1ns/1ps
// Far side of the link: wired-AND bus, other nodes may pull it dominant
module cbm_bus_node (
    input wire logic bus_transmit_pin,
    input wire logic dominant,
    output logic bus_receive_pin
);
    // Recessive 1 whenever no party drives dominant
    assign bus_receive_pin = bus_transmit_pin & ~dominant;
endmodule : cbm_bus_node

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rx_pin, tx_pin, cpu_wait, tport, tin, clk_run, clk_sel, dom;
    int n_fail = 0;
    int n_compared = 0;
    logic txd, rxd, wkp;
    int n_txd = 0;
    int n_rxd = 0;
    int n_wk = 0;
    logic [7:0] q;
    logic [7:0] lens [3] = '{8'h13, 8'h08, 8'h02};
    logic [7:0] prios [3] = '{8'h05, 8'h03, 8'h03};
    assign hready = hreadyout;
    cbm_ctrl #(.BIT_CYC(8), .WAKE_NS(100)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .bus_receive_pin(rx_pin), .bus_transmit_pin(tx_pin),
        .cpu_wait(cpu_wait), .bus_off(1'b0), .timer_port_pin(tport),
        .timer_input(tin), .module_clk_run(clk_run),
        .module_clock_select(clk_sel), .tx_done_pulse(txd),
        .rx_done_pulse(rxd), .wakeup_pulse(wkp));
    cbm_bus_node u_node (.bus_transmit_pin(tx_pin), .dominant(dom),
        .bus_receive_pin(rx_pin));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Each done or wakeup pulse stands one cycle, so it is counted once
    always @(posedge hclk) begin
        if (txd === 1'b1) n_txd <= n_txd + 1;
        if (rxd === 1'b1) n_rxd <= n_rxd + 1;
        if (wkp === 1'b1) n_wk <= n_wk + 1;
    end
    function automatic logic [9:0] ra(input logic [3:0] x,
                                      input logic [3:0] r);
        ra = {x, r, 2'b00};
    endfunction : ra
    task automatic acc(input logic w, input logic [9:0] a,
                       input logic [7:0] d, output logic [7:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask : acc
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] x;
        acc(1'b1, a, d, x);
    endtask : wr
    task automatic poll(input logic [9:0] a, input logic [7:0] m);
        int i;
        for (i = 0; i < 400; i++) begin
            acc(1'b0, a, 8'h00, q);
            if ((q & m) != 8'h00) break;
        end
    endtask : poll
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, cpu_wait, dom} = '0;
        haddr = '0;
        hwdata = '0;
        hsize = 3'h2;
        tport = 1'b1;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        acc(1'b0, 10'h000, 8'h00, q); chk(q, 8'h01);
        acc(1'b0, 10'h018, 8'h00, q); chk(q, 8'h07);
        acc(1'b0, 10'h3fc, 8'h00, q); chk(q, 8'h00);
        wr(10'h004, 8'h05);
        acc(1'b0, 10'h004, 8'h00, q); chk(q, 8'h05);
        chk({7'h0, clk_sel}, 8'h01);
        for (int b = 0; b < 3; b++) begin
            for (int i = 0; i < 8; i++)
                wr(ra(4'(5 + b), 4'(4 + i)), 8'(b * 16 + i + 1));
            wr(ra(4'(5 + b), 4'hc), lens[b]);
            wr(ra(4'(5 + b), 4'hd), prios[b]);
        end
        wr(10'h000, 8'h00);
        wr(10'h004, 8'h00);
        acc(1'b0, 10'h004, 8'h00, q); chk(q, 8'h05);
        poll(10'h000, 8'h10); chk(q & 8'h10, 8'h10);
        $display("test done: config");
        wr(10'h000, 8'h08);
        wr(10'h018, 8'h07);
        poll(10'h018, 8'h07); chk(q, 8'h02);
        acc(1'b0, ra(4'h4, 4'hc), 8'h00, q); chk(q & 8'h0f, 8'h08);
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, ra(4'h4, 4'(4 + i)), 8'h00, q);
            chk(q, 8'(16 + i + 1));
        end
        chk({7'h0, tx_pin}, 8'h01);
        wr(ra(4'h4, 4'h4), 8'hee);
        acc(1'b0, ra(4'h4, 4'h4), 8'h00, q); chk(q, 8'h11);
        poll(10'h018, 8'h04); chk(q, 8'h06);
        poll(10'h018, 8'h01); chk(q, 8'h07);
        acc(1'b0, ra(4'h4, 4'hc), 8'h00, q); chk(q, 8'h13);
        acc(1'b0, ra(4'h4, 4'h4), 8'h00, q); chk(q, 8'h21);
        $display("test done: priority");
        wr(10'h000, 8'h01);
        acc(1'b0, 10'h000, 8'h00, q); chk(q, 8'h01);
        wr(10'h004, 8'h00);
        wr(10'h000, 8'h00);
        poll(10'h000, 8'h10);
        wr(10'h000, 8'h02);
        acc(1'b0, 10'h000, 8'h00, q); chk(q, 8'h16);
        dom <= 1'b1;
        repeat (30) @(posedge hclk);
        dom <= 1'b0;
        repeat (4) @(posedge hclk);
        acc(1'b0, 10'h000, 8'h00, q); chk(q & 8'h06, 8'h00);
        $display("test done: sleep");
        wr(10'h000, 8'h01);
        wr(10'h004, 8'h02);
        wr(10'h000, 8'h00);
        poll(10'h000, 8'h10);
        wr(10'h000, 8'h02);
        dom <= 1'b1;
        repeat (5) @(posedge hclk);
        dom <= 1'b0;
        repeat (4) @(posedge hclk);
        acc(1'b0, 10'h000, 8'h00, q); chk(q, 8'h16);
        dom <= 1'b1;
        repeat (30) @(posedge hclk);
        dom <= 1'b0;
        repeat (4) @(posedge hclk);
        acc(1'b0, 10'h000, 8'h00, q); chk(q & 8'h06, 8'h00);
        $display("test done: filtered wakeup");
        wr(10'h000, 8'h20);
        cpu_wait <= 1'b1;
        @(posedge hclk);
        @(negedge hclk);
        chk({7'h0, clk_run}, 8'h00);
        chk({7'h0, tin}, 8'h01);
        cpu_wait <= 1'b0;
        @(posedge hclk);
        $display("test done: wait and timer");
        chk(8'(n_txd), 8'h03);
        chk(8'(n_rxd), 8'h03);
        chk(8'(n_wk), 8'h02);
        end_sim();
    end
endmodule : tb_top
